/* File: hdl/function_router.v */
`timescale 1ns/1ns
`default_nettype none
`include "motor_cmd_map.vh"

module function_router
(
   // Levels and edges of all inputs
   input  wire [`NUM_INPUTS-1:0]             level_in,
   input  wire [`NUM_INPUTS-1:0]             rise_in,
   // Function selector of every input, input 0 lowest
   input  wire [`NUM_INPUTS*`FUNC_WIDTH-1:0] func_sel_in,
   // Combined command levels and edges per function code
   output wire                               on_level_out,
   output wire                               on_rise_out,
   output wire                               cw_level_out,
   output wire                               cw_rise_out,
   output wire                               rev_level_out,
   output wire                               rev_rise_out
);

   wire [`NUM_INPUTS-1:0] is_on;
   wire [`NUM_INPUTS-1:0] is_cw;
   wire [`NUM_INPUTS-1:0] is_rev;

   // Any input may carry any function code
   genvar i;
   generate
      for (i = 0; i < `NUM_INPUTS; i = i + 1)
      begin : g_route
         assign is_on[i]  = func_sel_in[i*`FUNC_WIDTH +: `FUNC_WIDTH] == `FUNC_ON_OR_CW; // R16
         assign is_cw[i]  = func_sel_in[i*`FUNC_WIDTH +: `FUNC_WIDTH] == `FUNC_CW_OR_CCW;
         assign is_rev[i] = func_sel_in[i*`FUNC_WIDTH +: `FUNC_WIDTH] == `FUNC_REVERSE;
      end
   endgenerate

   // Several inputs on one code combine by OR
   assign on_level_out  = |(level_in & is_on);
   assign on_rise_out   = |(rise_in & is_on);
   assign cw_level_out  = |(level_in & is_cw);
   assign cw_rise_out   = |(rise_in & is_cw);
   assign rev_level_out = |(level_in & is_rev);
   assign rev_rise_out  = |(rise_in & is_rev);

endmodule
`default_nettype wire

/* File: hdl/input_edge_sampler.v */
`timescale 1ns/1ns
`default_nettype none
`include "motor_cmd_map.vh"

module input_edge_sampler
(
   // Clock and reset
   input  wire                    ref_clk_in,
   input  wire                    resetn_in,
   // Digital inputs
   input  wire [`NUM_INPUTS-1:0]  digital_in,
   // Registered levels and one-cycle rising edges
   output reg  [`NUM_INPUTS-1:0]  level_out,
   output wire [`NUM_INPUTS-1:0]  rise_out
);

   reg [`NUM_INPUTS-1:0] prev_level;

   // Sample each input and hold last sample
   always @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         level_out  <= {`NUM_INPUTS{1'b0}};
         prev_level <= {`NUM_INPUTS{1'b0}};
      end
      else
      begin
         level_out  <= digital_in;
         prev_level <= level_out;
      end
   end

   // Edge where sample rose since previous cycle
   genvar i;
   generate
      for (i = 0; i < `NUM_INPUTS; i = i + 1)
      begin : g_edge
         assign rise_out[i] = level_out[i] & ~prev_level[i]; // R18
      end
   endgenerate

endmodule
`default_nettype wire

/* File: hdl/motor_cmd_map.vh */
`ifndef MOTOR_CMD_MAP_VH
`define MOTOR_CMD_MAP_VH

// Command source selector: digital inputs
`define SRC_DIGITAL_INPUTS 4'h2

// Control method selector values
`define METHOD_TWO_WIRE_LEVEL 2'h0
`define METHOD_TWO_WIRE_ANY 2'h1
`define METHOD_THREE_WIRE 2'h2

// Digital input function codes
`define FUNC_LOCKED 4'h0
`define FUNC_ON_OR_CW 4'h1
`define FUNC_CW_OR_CCW 4'h2
`define FUNC_REVERSE 4'hc

// Reset values of the function selectors (inputs 0..3)
`define RST_FUNC_IN0 4'h1
`define RST_FUNC_IN1 4'h2
`define RST_FUNC_IN2 4'hc
`define RST_FUNC_IN3 4'h0

// Number of digital inputs and width of a function code
`define NUM_INPUTS 4
`define FUNC_WIDTH 4

`endif

/* File: hdl/motor_run_direction_decoder.v */
// Behaviour
// R1: method selector picks two-wire or three-wire
// R2: digital inputs act only when source is 2
// R3: method 2: CW setpoint, CCW inverted, none stops
// R4: method 2: both high keeps first active
// R5: method 2: reverse only after stop at 0 Hz
// R6: method 3: level changes act at any time
// R7: method 3: reverse without waiting for 0 Hz
// R8: method 3: both low or high stops
// R9: three-wire enable held high while running
// R10: three-wire: enable low stops, directions ignored
// R11: three-wire: CW edge, CCW low, runs setpoint
// R12: three-wire: CCW edge, CW low, runs inverted
// R13: three-wire: both low hold, both high stop
// R14: three-wire default functions 1, 2, 12
// R15: two-wire default functions 1 and 2
// R16: any input carries any function code
// R17: method 1: run level plus reverse level
// R18: rising edge from current versus previous sample
// R19: outputs run, invert, stop; stop wins
// R20: reset requests stop, clears remembered state
`timescale 1ns/1ns
`default_nettype none
`include "motor_cmd_map.vh"

module motor_run_direction_decoder
(
   // Clock and reset
   input  wire                    ref_clk_in,
   input  wire                    resetn_in,
   // Digital inputs
   input  wire [`NUM_INPUTS-1:0]  digital_in,
   // Configuration
   input  wire [3:0]              command_source_select_in,
   input  wire [1:0]              control_method_select_in,
   input  wire                    func_load_in,
   input  wire [3:0]              input0_function_select_in,
   input  wire [3:0]              input1_function_select_in,
   input  wire [3:0]              input2_function_select_in,
   input  wire [3:0]              input3_function_select_in,
   // Drive status
   input  wire                    at_zero_hz_in,
   // Requests to the drive
   output reg                     run_out,
   output reg                     invert_setpoint_out,
   output reg                     ramp_down_stop_out,
   output reg                     cmd_active_out
);

   // Direction states, one-hot
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_CW   = 3'b010;
   localparam [2:0] ST_CCW  = 3'b100;

   reg  [`NUM_INPUTS*`FUNC_WIDTH-1:0] func_sel;
   reg  [2:0]                         state;
   reg  [2:0]                         next_state;
   reg                                next_run;
   reg                                next_invert;
   reg                                next_stop;
   reg  [2:0]                         last_dir;
   reg  [2:0]                         next_last_dir;
   wire [`NUM_INPUTS-1:0]             level;
   wire [`NUM_INPUTS-1:0]             rise;
   wire                               on_level;
   wire                               on_rise;
   wire                               cw_level;
   wire                               cw_rise;
   wire                               rev_level;
   wire                               rev_rise;
   wire                               dig_source;
   wire                               is_method_one;
   wire                               cw_cmd;
   wire                               cw_cmd_rise;
   wire                               ccw_cmd;
   wire                               ccw_cmd_rise;

   // Function selectors loaded from ports; defaults at reset
   always @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         func_sel <= {`RST_FUNC_IN3, `RST_FUNC_IN2, `RST_FUNC_IN1, `RST_FUNC_IN0}; // R14
      end
      else if (func_load_in)
      begin
         func_sel <= {input3_function_select_in, input2_function_select_in,
                      input1_function_select_in, input0_function_select_in};
      end
   end

   // Input sampling and edge detection
   input_edge_sampler input_edge_sampler_i
   (
      .ref_clk_in (ref_clk_in),
      .resetn_in  (resetn_in),
      .digital_in (digital_in),
      .level_out  (level),
      .rise_out   (rise)
   );

   // Map inputs onto commands by function code
   function_router function_router_i
   (
      .level_in      (level),
      .rise_in       (rise),
      .func_sel_in   (func_sel),
      .on_level_out  (on_level),
      .on_rise_out   (on_rise),
      .cw_level_out  (cw_level),
      .cw_rise_out   (cw_rise),
      .rev_level_out (rev_level),
      .rev_rise_out  (rev_rise)
   );

   assign dig_source = command_source_select_in == `SRC_DIGITAL_INPUTS; // R2

   // Method 1 chosen when input 1 or 3 carries the reverse code and no function 2 level is high
   assign is_method_one = |{func_sel[4+:4] == `FUNC_REVERSE,
                            func_sel[12+:4] == `FUNC_REVERSE} & ~cw_level; // R17

   // Two-wire: function 1 is CW, function 2 is CCW
   // Three-wire: function 1 enables, 2 is CW start, 12 is CCW start
   assign cw_cmd       = (control_method_select_in == `METHOD_THREE_WIRE) ? cw_level : on_level; // R15
   assign cw_cmd_rise  = cw_rise;
   assign ccw_cmd      = (control_method_select_in == `METHOD_THREE_WIRE) ? rev_level : cw_level;
   assign ccw_cmd_rise = rev_rise;

   // Next command from method, state and inputs
   always @*
   begin
      next_state    = state;
      next_last_dir = last_dir;
      if (!dig_source)
      begin
         next_state = ST_IDLE; // R2
      end
      else
      begin
         case (control_method_select_in) // R1
            `METHOD_TWO_WIRE_LEVEL:
            begin
               if (is_method_one)
               begin
                  // Run level with reverse level
                  if (!on_level)
                     next_state = ST_IDLE; // R17
                  else if (rev_level)
                     next_state = ST_CCW;
                  else
                     next_state = ST_CW;
               end
               else
               begin
                  case (state)
                     ST_IDLE:
                     begin
                        // New direction only once at standstill
                        if (at_zero_hz_in) // R5
                        begin
                           if (cw_cmd)
                              next_state = ST_CW; // R3
                           else if (ccw_cmd)
                              next_state = ST_CCW; // R3
                        end
                        else if (cw_cmd && last_dir == ST_CW)
                           next_state = ST_CW;
                        else if (ccw_cmd && last_dir == ST_CCW)
                           next_state = ST_CCW;
                     end
                     // Keep first active; only its drop stops
                     ST_CW:
                        if (!cw_cmd)
                           next_state = ST_IDLE; // R4
                     ST_CCW:
                        if (!ccw_cmd)
                           next_state = ST_IDLE; // R4
                     default:
                        next_state = ST_IDLE;
                  endcase
               end
            end
            `METHOD_TWO_WIRE_ANY:
            begin
               // Levels act at once, no standstill wait
               if (cw_cmd && !ccw_cmd)
                  next_state = ST_CW; // R6 R7
               else if (ccw_cmd && !cw_cmd)
                  next_state = ST_CCW; // R6 R7
               else
                  next_state = ST_IDLE; // R8
            end
            `METHOD_THREE_WIRE:
            begin
               if (!on_level)
                  next_state = ST_IDLE; // R10
               else if (cw_cmd && ccw_cmd)
                  next_state = ST_IDLE; // R13
               else if (cw_cmd_rise && !ccw_cmd)
                  next_state = ST_CW; // R11
               else if (ccw_cmd_rise && !cw_cmd)
                  next_state = ST_CCW; // R12
            end
            default:
               next_state = ST_IDLE;
         endcase
      end
      if (next_state != ST_IDLE)
         next_last_dir = next_state;
   end

   // Output decode; stop outranks run
   always @*
   begin
      next_stop   = (next_state == ST_IDLE) | ~dig_source; // R19
      next_run    = ~next_stop;
      next_invert = (next_state == ST_CCW) ? 1'b1 :
                    (next_state == ST_CW) ? 1'b0 : last_dir == ST_CCW;
   end

   // State and output registers
   always @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         state               <= ST_IDLE; // R20
         last_dir            <= ST_IDLE;
         run_out             <= 1'b0;
         invert_setpoint_out <= 1'b0;
         ramp_down_stop_out  <= 1'b1;
         cmd_active_out      <= 1'b0;
      end
      else
      begin
         state               <= next_state;
         last_dir            <= next_last_dir;
         run_out             <= next_run;
         invert_setpoint_out <= next_invert;
         ramp_down_stop_out  <= next_stop;
         cmd_active_out      <= dig_source;
      end
   end

endmodule
`default_nettype wire

/* File: sim/motor_run_direction_decoder_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module motor_run_direction_decoder_chk
(
   // Clock and reset
   input wire logic       ref_clk_in,
   input wire logic       resetn_in,
   // Inputs
   input wire logic [3:0] digital_in,
   input wire logic [3:0] command_source_select_in,
   input wire logic [1:0] control_method_select_in,
   input wire logic       func_load_in,
   input wire logic [3:0] input0_function_select_in,
   input wire logic [3:0] input1_function_select_in,
   input wire logic [3:0] input2_function_select_in,
   input wire logic [3:0] input3_function_select_in,
   // Requests
   input wire logic       run_out,
   input wire logic       invert_setpoint_out,
   input wire logic       ramp_down_stop_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);
   // Cycles since configuration last changed, saturating at 3
   logic [22:0] last_cfg;
   logic [1:0]  age;
   wire  logic [15:0] sel = {input3_function_select_in, input2_function_select_in,
                             input1_function_select_in, input0_function_select_in};
   wire  logic [22:0] cfg = {command_source_select_in, control_method_select_in,
                             func_load_in, sel};
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         last_cfg <= 23'h0;
         age      <= 2'h0;
      end
      else
      begin
         last_cfg <= cfg;
         age      <= (cfg != last_cfg) ? 2'h0 : ((age == 2'h3) ? 2'h3 : age + 2'h1);
      end
   end
   // Settled modes with default mapping
   wire logic steady = age == 2'h3 && command_source_select_in == 4'h2 && func_load_in;
   wire logic two_any = steady && control_method_select_in == 2'h1 && sel == 16'h0021;
   wire logic three = steady && control_method_select_in == 2'h2 && sel == 16'h0c21;
   AST_STOP_WINS: assert property (!(run_out && ramp_down_stop_out))
      else $error("run and stop high together");
   AST_SOURCE_OFF: assert property (command_source_select_in != 4'h2 |=> ramp_down_stop_out && !run_out)
      else $error("run while source is not digital inputs");
   AST_TWO_CW: assert property ((two_any && digital_in[1:0] == 2'h1) ##2 two_any |-> run_out && !invert_setpoint_out)
      else $error("two-wire any CW not run");
   AST_TWO_CCW: assert property ((two_any && digital_in[1:0] == 2'h2) ##2 two_any |-> run_out && invert_setpoint_out)
      else $error("two-wire any CCW not inverted run");
   AST_TWO_STOP: assert property ((two_any && digital_in[0] == digital_in[1]) ##2 two_any |-> ramp_down_stop_out)
      else $error("two-wire any equal levels not stop");
   AST_THREE_OFF: assert property ((three && !digital_in[0]) ##2 three |-> ramp_down_stop_out && !run_out)
      else $error("three-wire enable low not stop");
   AST_THREE_CW: assert property ((three && digital_in[0] && !digital_in[2] && $rose(digital_in[1])) ##2 three |-> run_out && !invert_setpoint_out)
      else $error("three-wire CW edge not run");
   AST_THREE_CCW: assert property ((three && digital_in[0] && !digital_in[1] && $rose(digital_in[2])) ##2 three |-> run_out && invert_setpoint_out)
      else $error("three-wire CCW edge not inverted run");
   AST_THREE_BOTH: assert property ((three && digital_in[2:0] == 3'h7) ##2 three |-> ramp_down_stop_out)
      else $error("three-wire both directions not stop");
   // Main scenarios reached
   cover property (two_any && run_out && invert_setpoint_out);
   cover property (three && run_out);
   cover property (steady && control_method_select_in == 2'h0 && run_out);
endmodule
bind motor_run_direction_decoder motor_run_direction_decoder_chk motor_run_direction_decoder_chk_i
(
   .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .digital_in(digital_in),
   .command_source_select_in(command_source_select_in),
   .control_method_select_in(control_method_select_in), .func_load_in(func_load_in),
   .input0_function_select_in(input0_function_select_in),
   .input1_function_select_in(input1_function_select_in),
   .input2_function_select_in(input2_function_select_in),
   .input3_function_select_in(input3_function_select_in),
   .run_out(run_out), .invert_setpoint_out(invert_setpoint_out),
   .ramp_down_stop_out(ramp_down_stop_out)
);
`default_nettype wire

/* File: sim/motor_switch_model.sv */
`timescale 1ns/1ns
`default_nettype none
module motor_switch_model
(
   // Clock
   input  wire logic       ref_clk_in,
   // Switch positions
   input  wire logic [3:0] switch_in,
   // Digital input levels
   output var  logic [3:0] digital_out
);
   // Contacts settle on the falling edge; levels held as set
   initial digital_out = 4'h0;
   always @(negedge ref_clk_in)
      digital_out <= switch_in;
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic       ref_clk_in, resetn_in, func_load_in, at_zero;
   logic [3:0] switch, src, s0, s1, s2, s3;
   logic [1:0] method;
   wire  logic [3:0] digital;
   wire  logic       run, inv, stop, act;
   int         num_errors, samples_checked, cycles;
   // Clock and hang guard
   initial
   begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         test_done();
      end
   end
   motor_switch_model motor_switch_model_i
      (.ref_clk_in(ref_clk_in), .switch_in(switch), .digital_out(digital));
   motor_run_direction_decoder motor_run_direction_decoder_i
   (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .digital_in(digital),
      .command_source_select_in(src), .control_method_select_in(method),
      .func_load_in(func_load_in), .input0_function_select_in(s0),
      .input1_function_select_in(s1), .input2_function_select_in(s2),
      .input3_function_select_in(s3), .at_zero_hz_in(at_zero), .run_out(run),
      .invert_setpoint_out(inv), .ramp_down_stop_out(stop), .cmd_active_out(act)
   );
   task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic settle;
      repeat (4) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
   endtask
   task automatic cfg(input logic [3:0] sc, input logic [1:0] m, input logic [15:0] sel);
      src <= sc;
      method <= m;
      {s3, s2, s1, s0} <= sel;
      settle();
   endtask
   // Set switches and the zero-speed flag, then compare run, invert, stop
   task automatic step(input logic [3:0] d, input logic z, input logic [2:0] exp);
      switch <= d;
      at_zero <= z;
      settle();
      check("run_invert_stop", {1'b0, run, inv, stop}, {1'b0, exp});
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      {num_errors, samples_checked, cycles} = '0;
      {resetn_in, switch, at_zero, method} = '0;
      {func_load_in, src, s0, s1, s2, s3} = {1'b1, 4'h2, 4'h1, 4'h2, 4'hc, 4'h0};
      repeat (4) @(negedge ref_clk_in);
      check("reset", {act, run, inv, stop}, 4'h1);
      repeat (4) @(negedge ref_clk_in);
      resetn_in <= 1'b1;
      cfg(4'h0, 2'h1, 16'h0021);
      step(4'h1, 1'b0, 3'b001);
      check("active", {3'h0, act}, 4'h0);
      cfg(4'h2, 2'h1, 16'h0021);
      check("active", {3'h0, act}, 4'h1);
      step(4'h1, 1'b0, 3'b100);
      step(4'h2, 1'b0, 3'b110);
      step(4'h3, 1'b0, 3'b011);
      step(4'h1, 1'b0, 3'b100);
      step(4'h0, 1'b0, 3'b001);
      cfg(4'h2, 2'h0, 16'h0021);
      step(4'h1, 1'b0, 3'b100);
      step(4'h3, 1'b0, 3'b100);
      step(4'h2, 1'b0, 3'b001);
      step(4'h2, 1'b1, 3'b110);
      step(4'h3, 1'b0, 3'b110);
      step(4'h0, 1'b0, 3'b011);
      cfg(4'h2, 2'h1, 16'h1020);
      step(4'h8, 1'b0, 3'b100);
      step(4'h1, 1'b0, 3'b001);
      cfg(4'h2, 2'h0, 16'h00c1);
      step(4'h3, 1'b1, 3'b110);
      step(4'h1, 1'b1, 3'b100);
      cfg(4'h2, 2'h2, 16'h0c21);
      step(4'h1, 1'b0, 3'b100);
      step(4'h0, 1'b0, 3'b001);
      step(4'h1, 1'b0, 3'b001);
      step(4'h3, 1'b0, 3'b100);
      step(4'h1, 1'b0, 3'b100);
      step(4'h5, 1'b0, 3'b110);
      step(4'h7, 1'b0, 3'b011);
      step(4'h0, 1'b0, 3'b011);
      step(4'h2, 1'b0, 3'b011);
      // Reset while stopped forgets the last direction
      resetn_in <= 1'b0;
      repeat (2) @(negedge ref_clk_in);
      check("reset", {act, run, inv, stop}, 4'h1);
      resetn_in <= 1'b1;
      cfg(4'h2, 2'h0, 16'h0021);
      step(4'h2, 1'b0, 3'b001);
      step(4'h2, 1'b1, 3'b110);
      test_done();
   end
endmodule
`default_nettype wire
